// [core/comm_adapter_sense_status.sv]
// Sense decode, status words and status latches of one line adapter pair
//
// How it works
// - Interrupt sense returns interrupt_level_word, this adapter's bit set if bit 0-9 latched.
// - Function 111 is device sense; word loaded in data cycle.
// - Modifier 8 toggles test-receive flop; on forces receive data space.
// - Modifier 9 picks line 0 or line 1.
// - Modifier 10 shortens timeout to two seconds until timeout/turn/clear.
// - Modifier 11 sets enable; only 11 low with 15 high clears.
// - Ring sets end latch only enabled and uninitialized; program resets.
// - Modifier 12 clears adapter, drops terminal ready, keeps shift data.
// - Modifiers 13,14 choose operating, diagnostic or count word.
// - Modifier 15 on operating sense clears bits 0-7 and 9.
// - Parity, address check or protect set channel stop; protect bit 1.
// - Missing or stuck sync beyond three seconds sets timeout bit 2.
// - Transmit clear-to-send wait or unchained table end also times out.
// - Count word bit 3 suppresses timeout for that table.
// - Turnaround sets end bit 3 after pad; EOT/NAK need four ones.
// - DLE STICK, EOT, NAK ignored as turnarounds while in text.
// - Count reaching zero sets table complete unless count bit 1.
// - Transfer parity or VRC sets bit 5; VRC or overrun sends check as ones.
// - Block check mismatch sets bit 6.
// - Bit counter reaching one before steal sets overrun bit 7.
// - Initialize without clear while busy sets reject bit 9.
// - Bit 8 mirrors set ready; bit 10 carrier, ones on four-wire.
// - Count word: bits 0-2 jumpers, 4-15 count complemented.
// - Diagnostic word carries phase, trigger bits, shift register.
// - End trigger set by end characters, cleared by count 3 or clear.
`timescale 1ns/100ps
module comm_adapter_sense_status
  import sense_status_pkg::*;
#(
  parameter int          LINES          = 2,
  parameter int          INTERRUPT_LEVEL_WORD_BIT       = 0,
  parameter logic [2:0]  JUMPERS        = JUMPER_DEFAULT,
  parameter int          SEC_CYCLES     = int'(CLK_HZ)
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // Channel command and answer
  input  wire cmd_t             cmd,
  input  wire logic             intSense,
  output logic [15:0]           accumData,
  output logic                  accumValid,
  output logic                  irqReq,
  output logic                  stealBlock,
  // Per-line events from serial logic
  input  wire line_evt_t [1:0]  evt,
  input  wire logic [1:0][7:0]  shiftData,
  input  wire logic [1:0]       lineBit,
  input  wire logic [1:0][11:0] remainCount,
  input  wire logic [1:0]       transparent,
  input  wire logic [1:0]       suppTimeout,
  input  wire logic [1:0]       suppTableDone,
  input  wire logic [1:0]       fourWire,
  // Modem pins, asynchronous
  input  wire logic [1:0]       dsrPin,
  input  wire logic [1:0]       carrierPin,
  input  wire logic [1:0]       ctsPin,
  input  wire logic [1:0]       ringPin,
  input  wire logic [1:0]       rxDataPin,
  // Modem and line controls
  output logic [1:0]            dtrOut,
  output logic [1:0]            rxDataOut,
  output logic [1:0]            checkAllOnes,
  output logic [1:0]            contTimer,
  output logic [1:0]            adapterClear
);

  initial begin
    if (LINES != 2) $error("Only two lines supported");
    if (INTERRUPT_LEVEL_WORD_BIT < 0 || INTERRUPT_LEVEL_WORD_BIT > 15) $error("Bad INTERRUPT_LEVEL_WORD bit");
    if (SEC_CYCLES < 1) $error("Bad second length");
  end

  localparam int TO_LONG  = TIMEOUT_LONG_S * SEC_CYCLES;
  localparam int TO_SHORT = TIMEOUT_SHORT_S * SEC_CYCLES;

  typedef struct packed {
    logic [1:0][4:0]  sync1;   // First synchroniser stage
    logic [1:0][4:0]  sync2;   // Read by logic
    logic [1:0]       testRx;
    logic [1:0]       enable;
    logic [1:0]       contTmr;
    logic [1:0][15:0] status;  // Sticky latches, bit 0 = MSB
    logic [1:0]       endTrig;
    logic [1:0]       turnPend;
    logic [1:0]       dtrDrop;
    logic [1:0]       bccOnes;
    logic [1:0][31:0] timer;
    logic [15:0]      accum;
    logic             accumV;
    seq_state_t       seq;
  } state_t;

  state_t stReg;
  state_t stNext;

  // Index helper: modifier bit n where bit 0 is the MSB
  function automatic logic modBit(input logic [15:0] w, input int n);
    return w[15 - n];
  endfunction

  function automatic logic [15:0] setBit(input logic [15:0] w, input int n);
    logic [15:0] r;
    r = w;
    r[15 - n] = 1'b1;
    return r;
  endfunction

  logic       isSense;
  logic       isInit;
  logic [1:0] selWord;
  logic       ln;

  // Decode the command in its data cycle
  always_comb begin
    isSense = cmd.valid && (cmd.func == FUNC_SENSE_DEVICE);
    isInit  = cmd.valid && (cmd.func == FUNC_INITIALIZE);
    selWord = {modBit(cmd.modifier, MOD_SEL_HI),
               modBit(cmd.modifier, MOD_SEL_LO)};
    ln      = modBit(cmd.modifier, MOD_LINE_SEL);
  end

  // Next state of every latch and the answer register
  always_comb begin
    logic [15:0] st;
    logic        tmo;
    logic        clr;
    logic [31:0] limit;
    stNext = stReg;
    st = ZERO_WORD;
    tmo = 1'b0;
    clr = 1'b0;
    limit = 32'h0;
    stNext.sync1 = {{ringPin[1], ctsPin[1], carrierPin[1], dsrPin[1],
                     rxDataPin[1]},
                    {ringPin[0], ctsPin[0], carrierPin[0], dsrPin[0],
                     rxDataPin[0]}};
    stNext.sync2 = stReg.sync1;
    stNext.accumV = 1'b0;
    stNext.seq = SEQ_IDLE;
    for (int i = 0; i < 2; i++) begin
      st = stReg.status[i];
      clr = (isSense || isInit) && ln == i[0] &&
            modBit(cmd.modifier, MOD_CLEAR);
      // Error latches; a set survives the clear below only if the bit was not yet latched
      if (evt[i].parityErr || evt[i].addrCheck || evt[i].protectErr)
        st = setBit(st, OP_CHAN_STOP);
      if (evt[i].protectErr)
        st = setBit(st, OP_PROTECT);
      if (evt[i].turnaround && !(evt[i].turnPadOnly && evt[i].initialized
          && stReg.endTrig[i] == 1'b0 && 1'b0))
        stNext.turnPend[i] = 1'b1;
      // Turnarounds in text of stick/EOT/NAK class are ignored upstream
      if (stReg.turnPend[i] && evt[i].padStored &&
          (!evt[i].turnPadOnly || evt[i].padOnes >= 4'(PAD_ONES_MIN))) begin
        st = setBit(st, OP_END_RING);
        stNext.turnPend[i] = 1'b0;
      end
      if (stReg.sync2[i][4] && stReg.enable[i] && !evt[i].initialized)
        st = setBit(st, OP_END_RING);
      if (evt[i].countZero && !suppTableDone[i])
        st = setBit(st, OP_TABLE_DONE);
      if (evt[i].parityErr || evt[i].vrcErr)
        st = setBit(st, OP_PARITY);
      if (evt[i].bccMismatch)
        st = setBit(st, OP_BCC);
      if (evt[i].bitCountOne && evt[i].stealPending)
        st = setBit(st, OP_OVERRUN);
      if (isInit && ln == i[0] && !modBit(cmd.modifier, MOD_CLEAR) &&
          (evt[i].transmit || evt[i].charPhase))
        st = setBit(st, OP_REJECT);
      if (evt[i].vrcErr || (evt[i].bitCountOne && evt[i].stealPending))
        stNext.bccOnes[i] = 1'b1;
      // Timeout counting
      limit = stReg.contTmr[i] ? 32'(TO_SHORT) : 32'(TO_LONG);
      if (evt[i].syncMissing || evt[i].syncStuck ||
          (evt[i].transmit && evt[i].ctsWait)) begin
        if (stReg.timer[i] + 32'h1 >= limit) tmo = 1'b1;
        else stNext.timer[i] = stReg.timer[i] + 32'h1;
      end else begin
        stNext.timer[i] = 32'h0;
      end
      if (evt[i].transmit && evt[i].tableEndNoChain) tmo = 1'b1;
      if (tmo) begin
        stNext.timer[i] = 32'h0;
        stNext.contTmr[i] = 1'b0;
        if (!suppTimeout[i]) st = setBit(st, OP_TIMEOUT);
      end
      if (evt[i].dirChange) stNext.contTmr[i] = 1'b0;
      // End trigger
      if (evt[i].endChar) stNext.endTrig[i] = 1'b1;
      else if ((evt[i].dataCsa &&
                evt[i].charCount == 2'(END_CLEAR_COUNT)) || clr)
        stNext.endTrig[i] = 1'b0;
      // Commands addressed to this line
      if ((isSense || isInit) && ln == i[0]) begin
        if (modBit(cmd.modifier, MOD_CONT_TMR)) begin
          stNext.contTmr[i] = 1'b1;
          stNext.timer[i] = 32'h0;
        end
        if (modBit(cmd.modifier, MOD_ENABLE) && isSense)
          stNext.enable[i] = 1'b1;
        else if (isSense && modBit(cmd.modifier, MOD_RESET_IND))
          stNext.enable[i] = 1'b0;
      end
      if (isSense && ln == i[0]) begin
        if (modBit(cmd.modifier, MOD_TEST_RX))
          stNext.testRx[i] = !stReg.testRx[i];
        if (selWord == SEL_OPERATING &&
            modBit(cmd.modifier, MOD_RESET_IND)) begin
          // Clear only what was reported, keep fresh events on bits not yet latched
          st = st & ~(stReg.status[i] & 16'hff40);
        end
      end
      if (clr) begin
        stNext.contTmr[i] = 1'b0;
        stNext.dtrDrop[i] = 1'b1;
        stNext.bccOnes[i] = 1'b0;
        stNext.turnPend[i] = 1'b0;
      end else if (isInit && ln == i[0]) begin
        stNext.dtrDrop[i] = 1'b0;
      end
      stNext.status[i] = st;
    end
    // Answer in the data cycle
    if (intSense) begin
      stNext.accum = ZERO_WORD;
      if (stReg.status[0][15:6] != 10'h0 || stReg.status[1][15:6] != 10'h0)
        stNext.accum = setBit(ZERO_WORD, INTERRUPT_LEVEL_WORD_BIT);
      stNext.accumV = 1'b1;
    end else if (isSense) begin
      stNext.seq = SEQ_REPORT;
      stNext.accumV = 1'b1;
      stNext.accum = ZERO_WORD;
      if (selWord == SEL_OPERATING) begin
        stNext.accum = stReg.status[ln];
        stNext.accum[15 - OP_DSR] = stReg.sync2[ln][1];
        stNext.accum[15 - OP_CARRIER] =
          stReg.sync2[ln][2] | fourWire[ln];
      end else if (selWord == SEL_COUNT) begin
        stNext.accum = {JUMPERS, evt[ln].transmit, ~remainCount[ln]};
      end else if (selWord == SEL_DIAG) begin
        stNext.accum = {1'b1, evt[ln].charPhase, evt[ln].charCount[0],
                        !stReg.sync2[ln][3], transparent[ln],
                        evt[ln].textChar, stReg.endTrig[ln],
                        lineBit[ln], shiftData[ln]};
      end
    end
  end

  // One register for all state
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stReg <= '0;
      stReg.seq <= SEQ_IDLE;
    end else begin
      stReg <= stNext;
    end
  end

  // Outputs
  always_comb begin
    accumData  = stReg.accum;
    accumValid = stReg.accumV;
    irqReq     = 1'b0;
    stealBlock = 1'b0;
    for (int i = 0; i < 2; i++) begin
      irqReq = irqReq | (stReg.status[i][15:11] != 5'h0)
               | stReg.status[i][15 - OP_REJECT];
      stealBlock = stealBlock | stReg.status[i][15 - OP_CHAN_STOP];
      dtrOut[i]       = !stReg.dtrDrop[i];
      rxDataOut[i]    = stReg.sync2[i][0] & !stReg.testRx[i];
      checkAllOnes[i] = stReg.bccOnes[i];
      contTimer[i]    = stReg.contTmr[i];
      adapterClear[i] = stReg.dtrDrop[i];
    end
  end

  // Checks
  property p_toggle;
    @(posedge clk_sys) disable iff (!reset_n)
      (isSense && modBit(cmd.modifier, MOD_TEST_RX))
      |=> (stReg.testRx[$past(ln)] != $past(stReg.testRx[ln]));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle lost");

  property p_space;
    @(posedge clk_sys) disable iff (!reset_n)
      stReg.testRx[0] |-> rxDataOut[0] == 1'b0;
  endproperty
  a_space: assert property (p_space) else $error("rx not space");

  property p_answer;
    @(posedge clk_sys) disable iff (!reset_n)
      isSense |=> accumValid;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");

  property p_illegal;
    @(posedge clk_sys) disable iff (!reset_n)
      (isSense && selWord == SEL_ILLEGAL) |=> accumData == ZERO_WORD;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal nonzero");

  property p_enable;
    @(posedge clk_sys) disable iff (!reset_n)
      (isSense && modBit(cmd.modifier, MOD_ENABLE)) |=> stReg.enable[$past(ln)];
  endproperty
  a_enable: assert property (p_enable) else $error("enable not set");

  property p_stop;
    @(posedge clk_sys) disable iff (!reset_n)
      evt[0].parityErr |=> stealBlock ##0 irqReq;
  endproperty
  a_stop: assert property (p_stop) else $error("no channel stop");

  property p_dtr;
    @(posedge clk_sys) disable iff (!reset_n)
      (isSense && modBit(cmd.modifier, MOD_CLEAR)) |=> !dtrOut[$past(ln)];
  endproperty
  a_dtr: assert property (p_dtr) else $error("ready not dropped");

  property p_table;
    @(posedge clk_sys) disable iff (!reset_n)
      (evt[1].countZero && !suppTableDone[1])
      |=> stReg.status[1][15 - OP_TABLE_DONE];
  endproperty
  a_table: assert property (p_table) else $error("table bit");

  // Block check mismatch must latch unless an operating sense with modifier 15 on that line finds bit 6 already latched
  property p_bcc;
    @(posedge clk_sys) disable iff (!reset_n)
      evt[0].bccMismatch |=> stReg.status[0][15 - OP_BCC];
  endproperty
  a_bcc: assert property (p_bcc) else $error("bcc bit");

  property p_overrun;
    @(posedge clk_sys) disable iff (!reset_n)
      (evt[0].bitCountOne && evt[0].stealPending)
      |=> stReg.status[0][15 - OP_OVERRUN];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun bit");

  // Initialize without clear on a busy line is refused
  property p_reject;
    @(posedge clk_sys) disable iff (!reset_n)
      (isInit && !ln && !modBit(cmd.modifier, MOD_CLEAR) &&
       (evt[0].transmit || evt[0].charPhase))
      |=> stReg.status[0][15 - OP_REJECT];
  endproperty
  a_reject: assert property (p_reject) else $error("reject bit");

  // A clear in the same command wins over continue timer
  property p_cont;
    @(posedge clk_sys) disable iff (!reset_n)
      (isSense && modBit(cmd.modifier, MOD_CONT_TMR) &&
       !modBit(cmd.modifier, MOD_CLEAR)) |=> contTimer[$past(ln)];
  endproperty
  a_cont: assert property (p_cont) else $error("timer not set");

  c_sense_op: cover property (@(posedge clk_sys)
    isSense && selWord == SEL_OPERATING);
  c_sense_diag: cover property (@(posedge clk_sys)
    isSense && selWord == SEL_DIAG);
  c_int_sense: cover property (@(posedge clk_sys) intSense);
  c_timeout: cover property (@(posedge clk_sys)
    stReg.status[1][15 - OP_TIMEOUT]);
  c_ring: cover property (@(posedge clk_sys)
    stReg.status[0][15 - OP_END_RING]);

endmodule

// [core/sense_status_pkg.sv]
// Constants, encodings and carrier structs for the adapter sense-status block
package sense_status_pkg;

  // Command function codes
  localparam logic [2:0] FUNC_SENSE_DEVICE = 3'h7;
  localparam logic [2:0] FUNC_INITIALIZE   = 3'h5;

  // Modifier bit positions, numbered 0 = most significant of a 16-bit word
  localparam int MOD_TEST_RX   = 8;
  localparam int MOD_LINE_SEL  = 9;
  localparam int MOD_CONT_TMR  = 10;
  localparam int MOD_ENABLE    = 11;
  localparam int MOD_CLEAR     = 12;
  localparam int MOD_SEL_HI    = 13;
  localparam int MOD_SEL_LO    = 14;
  localparam int MOD_RESET_IND = 15;

  // Count word bit positions
  localparam int CNT_SUPP_TC   = 1;
  localparam int CNT_SUPP_TO   = 3;

  // Status word selections
  localparam logic [1:0] SEL_OPERATING = 2'h0;
  localparam logic [1:0] SEL_DIAG      = 2'h1;
  localparam logic [1:0] SEL_COUNT     = 2'h2;
  localparam logic [1:0] SEL_ILLEGAL   = 2'h3;

  // Operating word bit positions
  localparam int OP_CHAN_STOP  = 0;
  localparam int OP_PROTECT    = 1;
  localparam int OP_TIMEOUT    = 2;
  localparam int OP_END_RING   = 3;
  localparam int OP_TABLE_DONE = 4;
  localparam int OP_PARITY     = 5;
  localparam int OP_BCC        = 6;
  localparam int OP_OVERRUN    = 7;
  localparam int OP_DSR        = 8;
  localparam int OP_REJECT     = 9;
  localparam int OP_CARRIER    = 10;

  // Timeout figures
  localparam int  TIMEOUT_LONG_S  = 3;
  localparam int  TIMEOUT_SHORT_S = 2;
  localparam longint CLK_HZ       = 100000000;
  localparam int  END_CLEAR_COUNT = 3;
  localparam int  PAD_ONES_MIN    = 4;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [2:0]  JUMPER_DEFAULT = 3'h7;

  // Command presented on the channel
  typedef struct packed {
    logic        valid;     // One-cycle pulse: data cycle of the command
    logic [2:0]  func;
    logic        lineAddr;  // Line this adapter answers to
    logic [15:0] modifier;  // Bit 0 is the most significant
  } cmd_t;

  // Line events reported by the serial and channel logic
  typedef struct packed {
    logic        parityErr;
    logic        addrCheck;
    logic        protectErr;
    logic        syncMissing;   // Level: no sync pair since initialize
    logic        syncStuck;     // Level: sync characters continue
    logic        ctsWait;       // Level: request to send without clear
    logic        tableEndNoChain;
    logic        turnaround;    // Pulse: turnaround char decoded
    logic        turnPadOnly;   // EOT or NAK class needing pad ones
    logic        padStored;     // Pulse: following pad stored
    logic [3:0]  padOnes;
    logic        endChar;       // Pulse: end character decoded
    logic        textChar;      // Pulse: SOH or STX decoded
    logic        countZero;     // Pulse: byte count reached zero
    logic        vrcErr;
    logic        bccMismatch;
    logic        bitCountOne;   // Pulse: bit counter stepped to one
    logic        stealPending;
    logic        dataCsa;       // Pulse: data transfer cycle
    logic [1:0]  charCount;
    logic        transmit;
    logic        charPhase;
    logic        initialized;
    logic        dirChange;
  } line_evt_t;

  // Gray-coded command sequencer
  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_REPORT = 2'b01,
    SEQ_APPLY  = 2'b11
  } seq_state_t;

endpackage

// [sim/comm_adapter_sense_status_bench.sv]
// Self-checking bench for the adapter sense-status block
`timescale 1ns/100ps
module comm_adapter_sense_status_bench;
  import sense_status_pkg::*;

  logic                  clk_sys = 1'b0;
  logic                  reset_n = 1'b0;
  cmd_t                  cmd = '0;
  logic                  intSense = 1'b0;
  logic [15:0]           accumData;
  logic                  accumValid, irqReq, stealBlock;
  line_evt_t [1:0]       evt = '0;
  logic [1:0][7:0]       shiftData = '0;
  logic [1:0][11:0]      remainCount = '0;
  logic [1:0]            lineBit = '0, transparent = '0, fourWire = '0;
  logic [1:0]            suppTimeout = '0, suppTableDone = '0;
  logic [1:0]            dsrPin, carrierPin, ctsPin, ringPin, rxDataPin;
  logic [1:0]            dtrOut, rxDataOut, checkAllOnes;
  logic [1:0]            contTimer, adapterClear;
  logic [1:0]            carrierOn = 2'h2, ctsOn = '0, ringOn = '0;
  logic [1:0]            rxLevel = 2'h3;
  int                    error_cnt = 0, samples_checked = 0, i;
  integer                seed = 32'h5706b76a;
  logic                  ln;
  logic [15:0]           w;

  always #5 clk_sys = ~clk_sys;

  comm_adapter_sense_status #(.SEC_CYCLES(10)) u_comm_adapter_sense_status (
    .clk_sys(clk_sys), .reset_n(reset_n), .cmd(cmd), .intSense(intSense),
    .accumData(accumData), .accumValid(accumValid), .irqReq(irqReq),
    .stealBlock(stealBlock), .evt(evt), .shiftData(shiftData),
    .lineBit(lineBit), .remainCount(remainCount),
    .transparent(transparent), .suppTimeout(suppTimeout),
    .suppTableDone(suppTableDone), .fourWire(fourWire), .dsrPin(dsrPin),
    .carrierPin(carrierPin), .ctsPin(ctsPin), .ringPin(ringPin),
    .rxDataPin(rxDataPin), .dtrOut(dtrOut), .rxDataOut(rxDataOut),
    .checkAllOnes(checkAllOnes), .contTimer(contTimer),
    .adapterClear(adapterClear));

  modem_model u_modem_model (
    .clk_sys(clk_sys), .dtrOut(dtrOut), .carrierOn(carrierOn),
    .ctsOn(ctsOn), .ringOn(ringOn), .rxLevel(rxLevel), .dsrPin(dsrPin),
    .carrierPin(carrierPin), .ctsPin(ctsPin), .ringPin(ringPin),
    .rxDataPin(rxDataPin));

  // Modifier bit n sits at vector position 15-n
  function automatic logic [15:0] mb(input int n);
    return 16'h8000 >> n;
  endfunction

  function automatic logic [15:0] sel(input logic [1:0] s);
    return {13'h0000, s, 1'b0};
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One sense; the request stays up exactly one edge, answer is bounded
  task automatic sense(input logic [15:0] md, input logic l,
                       input logic ilv, output logic [15:0] got);
    int n;
    n = 0;
    @(posedge clk_sys);
    cmd.valid <= ~ilv;
    intSense <= ilv;
    cmd.func <= FUNC_SENSE_DEVICE;
    cmd.modifier <= md | (l ? mb(MOD_LINE_SEL) : 16'h0000);
    @(posedge clk_sys);
    cmd.valid <= 1'b0;
    intSense <= 1'b0;
    #1;
    while (accumValid !== 1'b1 && n < 4) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 4) check(16'h0000, 16'h0001);
    got = accumData;
  endtask

  task automatic sc(input logic [15:0] md, input logic l,
                    input logic [15:0] exp);
    logic [15:0] g;
    sense(md, l, 1'b0, g);
    check(g, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic close_out;
    $display("Checks made %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end

  initial begin
    idle(20);
    reset_n <= 1'b1;
    idle(4);
    check({14'h0, rxDataOut}, 16'h0003);
    sc(sel(SEL_OPERATING), 1'b0, 16'h0080);
    sc(sel(SEL_OPERATING), 1'b1, 16'h00a0);
    // Protect violation on line 0, refused selection must keep the latches
    @(posedge clk_sys) evt[0].protectErr <= 1'b1;
    @(posedge clk_sys) evt[0].protectErr <= 1'b0;
    sc(sel(SEL_ILLEGAL) | mb(MOD_RESET_IND), 1'b0, 16'h0000);
    check({14'h0, irqReq, stealBlock}, 16'h0003);
    sense(16'h0000, 1'b0, 1'b1, w);
    check(w, 16'h8000);
    sc(mb(MOD_RESET_IND), 1'b0, 16'hc080);
    sc(16'h0000, 1'b0, 16'h0080);
    check({15'h0, irqReq}, 16'h0000);
    // VRC error and table complete on line 1
    @(posedge clk_sys) evt[1].vrcErr <= 1'b1;
    @(posedge clk_sys) evt[1].vrcErr <= 1'b0;
    #1;
    check({15'h0, checkAllOnes[1]}, 16'h0001);
    evt[1].countZero <= 1'b1;
    @(posedge clk_sys) evt[1].countZero <= 1'b0;
    sc(mb(MOD_RESET_IND), 1'b1, 16'h0ca0);
    suppTableDone[1] <= 1'b1;
    @(posedge clk_sys) evt[1].countZero <= 1'b1;
    @(posedge clk_sys) evt[1].countZero <= 1'b0;
    sc(16'h0000, 1'b1, 16'h00a0);
    // Missing sync held past three short seconds, suppressed then not
    suppTimeout[1] <= 1'b1;
    evt[1].syncMissing <= 1'b1;
    idle(40);
    sc(16'h0000, 1'b1, 16'h00a0);
    suppTimeout[1] <= 1'b0;
    idle(40);
    evt[1].syncMissing <= 1'b0;
    sc(mb(MOD_RESET_IND), 1'b1, 16'h20a0);
    sc(16'h0000, 1'b1, 16'h00a0);
    // Ring is ignored until enabled; disable comes with the reset
    ringOn[0] <= 1'b1;
    idle(5);
    sc(mb(MOD_ENABLE), 1'b0, 16'h0080);
    idle(5);
    sc(16'h0000, 1'b0, 16'h1080);
    sc(mb(MOD_RESET_IND), 1'b0, 16'h1080);
    sc(16'h0000, 1'b0, 16'h0080);
    ringOn[0] <= 1'b0;
    // Random count and diagnostic words, either line
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      ln = $random(seed);
      remainCount[ln] <= $random(seed);
      shiftData[ln] <= $random(seed);
      lineBit[ln] <= $random(seed);
      transparent[ln] <= $random(seed);
      evt[ln].transmit <= $random(seed);
      @(posedge clk_sys);
      sense(sel(SEL_COUNT), ln, 1'b0, w);
      check(w, {JUMPER_DEFAULT, evt[ln].transmit, ~remainCount[ln]});
      sense(sel(SEL_DIAG), ln, 1'b0, w);
      check(w & 16'h99ff, {4'h9, transparent[ln], 2'h0, lineBit[ln],
                           shiftData[ln]});
    end
    // Test receive flop toggles the forced space on the line
    sc(mb(MOD_TEST_RX), 1'b0, 16'h0080);
    idle(3);
    check({15'h0, rxDataOut[0]}, 16'h0000);
    sc(mb(MOD_TEST_RX), 1'b0, 16'h0080);
    idle(3);
    check({15'h0, rxDataOut[0]}, 16'h0001);
    // Continue timer, then a clear drops it and terminal ready
    sc(mb(MOD_CONT_TMR), 1'b0, 16'h0080);
    check({15'h0, contTimer[0]}, 16'h0001);
    sc(mb(MOD_CLEAR), 1'b0, 16'h0080);
    check({14'h0, contTimer[0], dtrOut[0]}, 16'h0000);
    // Check errors and a refused initialize on a transmitting line 0
    idle(8);
    @(posedge clk_sys);
    evt[0].bccMismatch <= 1'b1;
    evt[0].bitCountOne <= 1'b1;
    evt[0].stealPending <= 1'b1;
    evt[0].transmit <= 1'b1;
    cmd.valid <= 1'b1;
    cmd.func <= FUNC_INITIALIZE;
    cmd.modifier <= 16'h0000;
    @(posedge clk_sys);
    evt[0].bccMismatch <= 1'b0;
    evt[0].bitCountOne <= 1'b0;
    evt[0].stealPending <= 1'b0;
    evt[0].transmit <= 1'b0;
    cmd.valid <= 1'b0;
    #1;
    check({15'h0, checkAllOnes[0]}, 16'h0001);
    sc(mb(MOD_RESET_IND), 1'b0, 16'h0340);
    idle(4);
    close_out();
  end
endmodule

// [sim/modem_model.sv]
// Behavioural modem pair facing the adapter's data set pins
`timescale 1ns/100ps
module modem_model #(
  parameter int DSR_DELAY = 4
) (
  // Clock
  input  wire logic       clk_sys,
  // Terminal ready from the adapter, line conditions from the bench
  input  wire logic [1:0] dtrOut,
  input  wire logic [1:0] carrierOn,
  input  wire logic [1:0] ctsOn,
  input  wire logic [1:0] ringOn,
  input  wire logic [1:0] rxLevel,
  // Data set pins
  output logic [1:0]      dsrPin,
  output logic [1:0]      carrierPin,
  output logic [1:0]      ctsPin,
  output logic [1:0]      ringPin,
  output logic [1:0]      rxDataPin
);
  logic [DSR_DELAY-1:0][1:0] dtrPipe;

  initial dtrPipe = '1;

  // Set ready trails terminal ready: the set goes on hook only after a delay
  always @(posedge clk_sys) begin
    dtrPipe <= {dtrPipe[DSR_DELAY-2:0], dtrOut};
  end

  // Line conditions pass straight to the pins
  assign dsrPin     = dtrPipe[DSR_DELAY-1];
  assign carrierPin = carrierOn;
  assign ctsPin     = ctsOn;
  assign ringPin    = ringOn;
  assign rxDataPin  = rxLevel;
endmodule
